/* File: verilog/ext_mem_pin_partition_mux.sv */
/*
 * Pin partition multiplexer between the asynchronous memory interface
 * and GPIO, with an AXI4-Lite register slave.
 * Assumes pads are resolved outside from pad_out/pad_oe, and that the
 * memory controller and GPIO block run on aclk.
 */
`default_nettype none

//
// Overview of operation
// - Reset strap splits pins between address, GPIO
// - Software may rewrite partition after reset
// - Address bit count selectable zero to fourteen
// - Unused shared pins become GPIO, except A1/A2
// - Address run contiguous upward from bank bit
// - Address pins one and two always enabled out of reset
// - Only 8-bit and 16-bit data widths
// - 16-bit: bank1 halfword bit, bank0 bit 14
// - 8-bit with ba0_sel: bank pins carry two byte bits
// - Code 0010 gives 16-bit muxed flash
// - GPIO 54 pad carries bank bit 0 under codes A, 8, 2, 0
// - Bank bit one enabled except code 1101 and undefined codes
// - Upper data only under codes 0010, 0000
// - Selection applied without any consistency check
// - Five software pin-mux registers govern groups
// - Strap pins go to address or GPIO per partition after capture
//
module ext_mem_pin_partition_mux
    import pin_mux_pkg::*;
(
    // Clock, reset, enable
    input  wire  logic                              aclk,
    input  wire  logic                              aresetn,
    input  wire  logic                              ce,
    // AXI4-Lite write
    input  wire  logic [pin_mux_pkg::ADDR_W-1:0]    awaddr,
    input  wire  logic                              awvalid,
    output var   logic                              awready,
    input  wire  logic [31:0]                       wdata,
    input  wire  logic [3:0]                        wstrb,
    input  wire  logic                              wvalid,
    output var   logic                              wready,
    output var   logic [1:0]                        bresp,
    output var   logic                              bvalid,
    input  wire  logic                              bready,
    // AXI4-Lite read
    input  wire  logic [pin_mux_pkg::ADDR_W-1:0]    araddr,
    input  wire  logic                              arvalid,
    output var   logic                              arready,
    output var   logic [31:0]                       rdata,
    output var   logic [1:0]                        rresp,
    output var   logic                              rvalid,
    input  wire  logic                              rready,
    // Memory controller side
    input  wire  logic [pin_mux_pkg::BADDR_W-1:0]   mc_byte_addr,
    input  wire  logic [7:0]                        mc_data_hi_out,
    input  wire  logic                              mc_data_hi_oe,
    output var   logic [7:0]                        mc_data_hi_in,
    output var   logic                              async_mem_full_rate,
    output var   logic                              async_mem_wide,
    // GPIO controller side
    input  wire  logic [pin_mux_pkg::NGPIO-1:0]     gpio_out,
    input  wire  logic [pin_mux_pkg::NGPIO-1:0]     gpio_oe,
    output var   logic [pin_mux_pkg::NGPIO-1:0]     gpio_in,
    // Other peripheral mux selections
    output var   logic [31:0]                       video_in_mux,
    output var   logic [31:0]                       video_out_mux,
    output var   logic [31:0]                       gen_io_mux,
    output var   logic [31:0]                       serial_card_mux,
    // Pads
    input  wire  logic [pin_mux_pkg::NPADS-1:0]     pad_in,
    output var   logic [pin_mux_pkg::NPADS-1:0]     pad_out,
    output var   logic [pin_mux_pkg::NPADS-1:0]     pad_oe
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NPADS-1:0]   pad_m_q;
    logic [NPADS-1:0]   pad_s_q;
    logic [3:0]         strap_sync;
    logic [3:0]         strap_q;
    mem_cfg_t           cfg_q;
    logic [31:0]        vin_q;
    logic [31:0]        vout_q;
    logic [31:0]        gio_q;
    logic [31:0]        ser_q;
    logic [NPADS-1:0]   mem_own;
    logic [NPADS-1:0]   mem_val;
    logic [NPADS-1:0]   pad_out_d;
    logic [NPADS-1:0]   pad_oe_d;
    logic [NPADS-1:0]   pad_out_q;
    logic [NPADS-1:0]   pad_oe_q;
    logic [NGPIO-1:0]   gpio_in_d;
    logic [NGPIO-1:0]   gpio_in_q;
    logic [7:0]         hi_in_q;
    logic [4:0]         run_len;
    logic [RUN_LEN-1:0] run_vec;
    logic               awready_q;
    logic               wready_q;
    logic               aw_got_q;
    logic               w_got_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic [ADDR_W-1:0]  waddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               arready_q;
    logic               rvalid_q;
    logic [1:0]         rresp_q;
    logic [31:0]        rdata_q;
    logic [31:0]        rd_d;
    logic               rd_err;
    logic [31:0]        cfg_w;
    logic [ADDR_W-1:0]  wofs;
    logic [ADDR_W-1:0]  rofs;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // Pad input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (ce) begin
            pad_m_q <= pad_in;
            pad_s_q <= pad_m_q;
        end
    end

    assign strap_sync = pad_s_q[STRAP_LSB +: 4];

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // Tracks the pins for the whole reset, so the last value before
    // release is the one kept
    always_ff @(posedge aclk) begin
        if (ce && !aresetn) begin
            strap_q <= strap_sync;
        end
    end

    chk_strap_load: assert property (
        $past(!aresetn && ce) |-> strap_q == $past(strap_sync))
        else $error("strap not captured at reset");
    chk_strap_hold: assert property (
        $past(aresetn) |-> $stable(strap_q))
        else $error("strap changed after reset");

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign wofs  = {waddr_q[ADDR_W-1:2], 2'b00};
    assign cfg_w = merge_strb({24'h0, cfg_q}, wdata_q, wstrb_q);

    always_ff @(posedge aclk) begin
        if (ce) begin
            if (!aresetn) begin
                cfg_q <= strap_cfg(strap_sync);
                vin_q  <= 32'h0000_0000;
                vout_q <= 32'h0000_0000;
                gio_q  <= 32'h0000_0000;
                ser_q  <= 32'h0000_0000;
            end else if (aw_got_q && w_got_q) begin
                // No check against the peripherals in use
                unique case (wofs)
                    OFS_VIN:  vin_q  <= merge_strb(vin_q, wdata_q, wstrb_q);
                    OFS_VOUT: vout_q <= merge_strb(vout_q, wdata_q, wstrb_q);
                    OFS_MEM:  cfg_q  <= cfg_w[7:0];
                    OFS_GIO:  gio_q  <= merge_strb(gio_q, wdata_q, wstrb_q);
                    OFS_SER:  ser_q  <= merge_strb(ser_q, wdata_q, wstrb_q);
                    default: ;
                endcase
            end
        end
    end

    chk_mem_write: assert property (
        ce && aw_got_q && w_got_q && wofs == OFS_MEM && wstrb_q[0]
        |=> cfg_q == $past(wdata_q[7:0]))
        else $error("memory mux write not applied");

    // ------------------------------------------------------------
    // Partition decode per pad
    // ------------------------------------------------------------
    // Counts past the run length saturate to a full run
    assign run_len = (cfg_q.addr_cnt > 5'(RUN_LEN))
                   ? 5'(RUN_LEN) : cfg_q.addr_cnt;

    // Address lines follow the byte address; bank bit 0 is byte bit 0 in
    // 8-bit mode with ba0_sel set, and bit 14 of the word otherwise
    assign mem_val[0] = (cfg_q.ba0_sel && !cfg_q.data16)
                      ? mc_byte_addr[0]
                      : mc_byte_addr[BADDR_W-1];
    assign mem_val[HI_BASE-1:1] = mc_byte_addr[HI_BASE-1:1];
    assign mem_val[NPADS-1:HI_BASE] = mc_data_hi_out;

    for (genvar i = 0; i < NPADS; i++) begin : g_pad
        localparam int RP = run_pos(i);
        localparam int GI = gpio_idx(i);
        if (i == 3 || i == 4) begin : g_fixed
            assign mem_own[i] = 1'b1;
        end else if (i >= HI_BASE) begin : g_data
            assign mem_own[i] = cfg_q.data16;
            assign gpio_in_d[GI] = pad_s_q[i];
        end else begin : g_run
            assign mem_own[i] = 5'(RP) < run_len;
            assign run_vec[RP] = mem_own[i];
            assign gpio_in_d[GI] = pad_s_q[i];
        end
        // Anything not owned by the memory falls to GPIO
        assign pad_out_d[i] = mem_own[i] ? mem_val[i]
                                         : gpio_out[GI];
        assign pad_oe_d[i]  = mem_own[i]
                            ? (i >= HI_BASE ? mc_data_hi_oe : 1'b1)
                            : gpio_oe[GI];
    end

    // ------------------------------------------------------------
    // Registered pad and side outputs
    // ------------------------------------------------------------
    // Pads float during reset so the straps can be read; the address
    // function returns on the first enabled edge after release
    always_ff @(posedge aclk) begin
        if (ce) begin
            if (!aresetn) begin
                pad_out_q <= '0;
                pad_oe_q  <= '0;
                gpio_in_q <= '0;
                hi_in_q   <= 8'h00;
            end else begin
                pad_out_q <= pad_out_d;
                pad_oe_q  <= pad_oe_d;
                gpio_in_q <= gpio_in_d;
                hi_in_q   <= pad_s_q[NPADS-1:HI_BASE];
            end
        end
    end

    assign pad_out             = pad_out_q;
    assign pad_oe              = pad_oe_q;
    assign gpio_in             = gpio_in_q;
    assign mc_data_hi_in       = hi_in_q;
    assign async_mem_full_rate = cfg_q.full_rate;
    assign async_mem_wide      = cfg_q.data16;
    assign video_in_mux        = vin_q;
    assign video_out_mux       = vout_q;
    assign gen_io_mux          = gio_q;
    assign serial_card_mux     = ser_q;

    chk_latch_pins: assert property (
        $past(aresetn) && $past(ce) |-> pad_oe_q[4:3] == 2'b11)
        else $error("address pins one and two not driven");
    chk_run_contig: assert property (
        ((run_vec + 14'h0001) & run_vec) == 14'h0000)
        else $error("address run has a gap");
    chk_hi_data: assert property (
        $past(aresetn) && $past(ce) && !$past(cfg_q.data16)
        |-> pad_oe_q[NPADS-1:HI_BASE] == $past(gpio_oe[7:0]))
        else $error("upper data pads not GPIO in 8-bit mode");
    chk_ba_8bit: assert property (
        $past(aresetn) && $past(ce) && !$past(cfg_q.data16)
        && $past(cfg_q.ba0_sel) && $past(run_len) == 5'h0E
        |-> pad_out_q[1:0] == $past(mc_byte_addr[1:0]))
        else $error("8-bit bank address wrong");
    chk_ba_16bit: assert property (
        $past(aresetn) && $past(ce) && $past(cfg_q.data16)
        && $past(cfg_q.ba0_sel) && $past(run_len) == 5'h0E
        |-> pad_out_q[0] == $past(mc_byte_addr[16])
        && pad_out_q[1] == $past(mc_byte_addr[1]))
        else $error("16-bit bank address wrong");
    chk_code_1000: assert property (
        $past(!aresetn && ce) && $past(strap_sync) == 4'h8
        |-> cfg_q.ba0_sel && cfg_q.addr_cnt == 5'h0E && !cfg_q.data16)
        else $error("code 1000 decoded wrongly");
    chk_code_1101: assert property (
        $past(!aresetn && ce) && $past(strap_sync) == 4'hD
        |-> ##1 pad_oe_q[0] == $past(gpio_oe[8])
        && pad_oe_q[1] == $past(gpio_oe[9]))
        else $error("code 1101 did not free the address pads");
    chk_code_0010: assert property (
        $past(!aresetn && ce) && $past(strap_sync) == 4'h2
        |-> cfg_q.data16 && !cfg_q.ba0_sel && cfg_q.addr_cnt == 5'h0E)
        else $error("code 0010 decoded wrongly");

    cov_nand_boot: cover property ($past(!aresetn) && strap_q == 4'hD);
    cov_wide_drive: cover property (cfg_q.data16 && pad_oe_q[HI_BASE]);
    cov_sw_change: cover property (
        aw_got_q && w_got_q && wofs == OFS_MEM);

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (ce) begin
            if (!aresetn) begin
                awready_q <= 1'b0;
                wready_q  <= 1'b0;
                aw_got_q  <= 1'b0;
                w_got_q   <= 1'b0;
                bvalid_q  <= 1'b0;
                bresp_q   <= RESP_OKAY;
            end else begin
                awready_q <= awready_q ? !awvalid : !aw_got_q && !bvalid_q;
                wready_q  <= wready_q ? !wvalid : !w_got_q && !bvalid_q;
                if (awvalid && awready_q) begin
                    aw_got_q <= 1'b1;
                    waddr_q  <= awaddr;
                end
                if (wvalid && wready_q) begin
                    w_got_q <= 1'b1;
                    wdata_q <= wdata;
                    wstrb_q <= wstrb;
                end
                if (aw_got_q && w_got_q) begin
                    aw_got_q <= 1'b0;
                    w_got_q  <= 1'b0;
                    bvalid_q <= 1'b1;
                    bresp_q  <= (wofs > OFS_STAT) ? RESP_SLVERR : RESP_OKAY;
                end else if (bvalid_q && bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign rofs = {araddr[ADDR_W-1:2], 2'b00};

    always_comb begin
        rd_err = 1'b0;
        unique case (rofs)
            OFS_VIN:  rd_d = vin_q;
            OFS_VOUT: rd_d = vout_q;
            OFS_MEM:  rd_d = {24'h0, cfg_q};
            OFS_GIO:  rd_d = gio_q;
            OFS_SER:  rd_d = ser_q;
            OFS_STAT: rd_d = {4'h0, mem_own, strap_q};
            default: begin
                rd_d   = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (ce) begin
            if (!aresetn) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b0;
                rresp_q   <= RESP_OKAY;
                rdata_q   <= 32'h0000_0000;
            end else begin
                arready_q <= arready_q ? !arvalid : !rvalid_q;
                if (arvalid && arready_q) begin
                    rvalid_q <= 1'b1;
                    rdata_q  <= rd_d;
                    rresp_q  <= rd_err ? RESP_SLVERR : RESP_OKAY;
                end else if (rvalid_q && rready) begin
                    rvalid_q <= 1'b0;
                end
            end
        end
    end

    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

endmodule // ext_mem_pin_partition_mux

`default_nettype wire

/* File: verilog/pin_mux_pkg.sv */
/*
 * Constants, field layouts and strap decoding for the shared memory/GPIO
 * pin partition multiplexer.
 * Assumes one system clock domain; no other file is needed.
 */
`default_nettype none

package pin_mux_pkg;

    // ------------------------------------------------------------
    // Pads and widths
    // ------------------------------------------------------------
    localparam int NPADS   = 24;  // 16 address-capable, 8 upper data
    localparam int NGPIO   = 22;  // GPIO 46..67
    localparam int RUN_LEN = 14;  // switchable address pads
    localparam int HI_BASE = 16;  // first upper data pad
    localparam int ADDR_W  = 8;
    localparam int BADDR_W = 17;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_VIN  = 8'h00;
    localparam logic [7:0] OFS_VOUT = 8'h04;
    localparam logic [7:0] OFS_MEM  = 8'h08;
    localparam logic [7:0] OFS_GIO  = 8'h0C;
    localparam logic [7:0] OFS_SER  = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Strap codes and memory field values
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_NAND   = 4'hD;
    localparam logic [3:0] CODE_A13    = 4'hC;
    localparam logic [3:0] CODE_A14_8  = 4'hA;
    localparam logic [3:0] CODE_BA0_8  = 4'h8;
    localparam logic [3:0] CODE_MUX16  = 4'h2;
    localparam logic [3:0] CODE_BA0_16 = 4'h0;
    localparam logic [4:0] CNT_NONE    = 5'h00;
    localparam logic [4:0] CNT_A13     = 5'h0D;
    localparam logic [4:0] CNT_FULL    = 5'h0E;
    localparam int         STRAP_LSB   = 10;  // pad of address bit 8

    // Memory mux register layout, bits [7:0]
    typedef struct packed {
        logic       full_rate;
        logic       data16;
        logic       ba0_sel;
        logic [4:0] addr_cnt;
    } mem_cfg_t;

    function automatic mem_cfg_t strap_cfg(input logic [3:0] s);
        mem_cfg_t c;
        c = '0;
        case (s)
            CODE_A13:    c.addr_cnt = CNT_A13;
            CODE_A14_8:  c.addr_cnt = CNT_FULL;
            CODE_BA0_8:  c = '{1'b0, 1'b0, 1'b1, CNT_FULL};
            CODE_MUX16:  c = '{1'b0, 1'b1, 1'b0, CNT_FULL};
            CODE_BA0_16: c = '{1'b0, 1'b1, 1'b1, CNT_FULL};
            default:     c.addr_cnt = CNT_NONE;
        endcase
        return c;
    endfunction

    // Position of a pad in the contiguous address run, -1 if none
    function automatic int run_pos(input int p);
        if (p == 0) return 13;
        if (p == 1 || p == 2) return p - 1;
        if (p >= 5 && p < HI_BASE) return p - 3;
        return -1;
    endfunction

    // GPIO bit carried by a pad (bit 0 is GPIO 46)
    function automatic int gpio_idx(input int p);
        if (p < 3) return p + 8;
        if (p < 5) return 0;
        if (p < HI_BASE) return p + 6;
        return p - HI_BASE;
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction

endpackage

`default_nettype wire

/* File: tb/ext_mem_model.sv */
/* Board and memory model on the shared pads: strap pulls, a 16-bit part
   driving the upper data byte, and released lines that never hold.
   Assumes pad_out/pad_oe come from the pin mux on the same clock. */
`default_nettype none
module ext_mem_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Pads from the mux
    input  wire logic [23:0] pad_out,
    input  wire logic [23:0] pad_oe,
    // Board setup
    input  wire logic [3:0]  strap,
    input  wire logic        wide,
    input  wire logic [7:0]  mem_data,
    output var  logic [23:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] last_q;
    // Released lines show the inverse of the last driven level
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 24; i++) begin
            if (!aresetn) last_q[i] <= 1'b0;
            else if (pad_oe[i]) last_q[i] <= pad_out[i];
        end
    end
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ~last_q[i];
            // Strap pulls win whenever nobody drives
            if (i > 9 && i < 14 && !pad_oe[i]) pad_in[i] = strap[i-10];
            if (i > 15 && wide && !pad_oe[i]) pad_in[i] = mem_data[i-16];
        end
    end
endmodule // ext_mem_model
`default_nettype wire

/* File: tb/ext_mem_pin_partition_mux_test.sv */
/* Self-checking bench: strap sweep, software override, register file and
   refusals, all against a behavioural model of the partition.
   Assumes pin_mux_pkg and ext_mem_model are compiled first. */
`default_nettype none
module ext_mem_pin_partition_mux_test
    import pin_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, mc_data_hi_oe = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        async_mem_full_rate, async_mem_wide;
    logic [7:0]  awaddr = '0, araddr = '0, mc_data_hi_out = '0;
    logic [7:0]  mem_data = '0, mc_data_hi_in, cur = '0;
    logic [31:0] wdata = '0, v, rdata, regs_m [5];
    logic [31:0] video_in_mux, video_out_mux, gen_io_mux, serial_card_mux;
    logic [3:0]  wstrb = '0, strap = 4'hD, s;
    logic [1:0]  bresp, rresp, r;
    logic [16:0] mc_byte_addr = '0;
    logic [21:0] gpio_out = '0, gpio_oe = '0, gpio_in;
    logic [23:0] pad_in, pad_out, pad_oe;
    logic [3:0]  codes [7] = '{4'hD, 4'hC, 4'hA, 4'h8, 4'h2, 4'h0, 4'h5};
    int          num_errors = 0;
    int          check_count = 0;

    ext_mem_pin_partition_mux i_ext_mem_pin_partition_mux (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .mc_byte_addr,
        .mc_data_hi_out, .mc_data_hi_oe, .mc_data_hi_in,
        .async_mem_full_rate, .async_mem_wide, .gpio_out, .gpio_oe,
        .gpio_in, .video_in_mux, .video_out_mux, .gen_io_mux,
        .serial_card_mux, .pad_in, .pad_out, .pad_oe
    );
    ext_mem_model i_ext_mem_model (
        .aclk, .aresetn, .pad_out, .pad_oe, .strap, .wide(cur[6]),
        .mem_data, .pad_in
    );

    // ----------------------------------------
    // Model and bus tasks
    // ----------------------------------------
    function automatic logic [7:0] strap_map(input logic [3:0] c);
        case (c)
            CODE_A13:    return 8'h0D;
            CODE_A14_8:  return 8'h0E;
            CODE_BA0_8:  return 8'h2E;
            CODE_MUX16:  return 8'h4E;
            CODE_BA0_16: return 8'h6E;
            default:     return 8'h00;
        endcase
    endfunction

    // Run order: pad1, pad2, pad5..pad15, pad0; pads 3 and 4 always held
    function automatic logic [23:0] own_mask(input logic [7:0] c);
        logic [23:0] m;
        int          kk;
        kk = (c[4:0] > 5'h0E) ? 14 : int'(c[4:0]);
        m = 24'h000018;
        for (int j = 0; j < kk; j++)
            m[j == 13 ? 0 : (j < 2 ? j + 1 : j + 3)] = 1'b1;
        if (c[6]) m[23:16] = 8'hFF;
        return m;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st, output logic [1:0] rs);
        bit ta, tw, sa, sw;
        ta = 0;
        tw = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            sa = awvalid && awready;
            sw = wvalid && wready;
            @(posedge aclk);
            ta = ta | sa;
            tw = tw | sw;
            awvalid <= !ta;
            wvalid <= !tw;
        end
        do begin
            @(negedge aclk);
            sa = bvalid;
            rs = bresp;
            @(posedge aclk);
        end while (!sa);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        bit sr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            sr = arvalid && arready;
            @(posedge aclk);
        end while (!sr);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            sr = rvalid;
            chk("rdata", e, sr ? rdata : e);
            chk("rresp", 32'(er), sr ? 32'(rresp) : 32'(er));
            @(posedge aclk);
        end while (!sr);
    endtask

    // Fresh random traffic, then pads compared once synchronisers settle
    task automatic stir_and_check(input logic [7:0] c);
        logic [23:0] m, src, eo, ee;
        logic [21:0] gi, gm;
        int          g;
        mc_byte_addr <= 17'($urandom);
        gpio_out <= 22'($urandom);
        gpio_oe <= 22'($urandom);
        mc_data_hi_out <= 8'($urandom);
        mc_data_hi_oe <= 1'($urandom);
        mem_data <= 8'($urandom);
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        m = own_mask(c);
        src = {mc_data_hi_out, mc_byte_addr[15:0]};
        src[0] = (c[5] && !c[6]) ? mc_byte_addr[0] : mc_byte_addr[16];
        gi = '0;
        gm = '0;
        for (int i = 0; i < 24; i++) begin
            g = i < 3 ? i + 8 : (i < 16 ? i + 6 : i - 16);
            eo[i] = m[i] ? src[i] : gpio_out[g];
            ee[i] = m[i] ? (i > 15 ? mc_data_hi_oe : 1'b1) : gpio_oe[g];
            if (!m[i]) gi[g] = pad_in[i];
            if (!m[i]) gm[g] = 1'b1;
        end
        chk("pad_oe", 32'(ee),
            32'(pad_oe));
        chk("pad_out", 32'(eo & ee),
            32'(pad_out & ee));
        chk("gpio_in", 32'(gi & gm), 32'(gpio_in & gm));
        chk("wide", 32'(c[6]), 32'(async_mem_wide));
        chk("rate", 32'(c[7]), 32'(async_mem_full_rate));
        if (c[6] && !mc_data_hi_oe)
            chk("data_in", 32'(pad_in[23:16]),
                32'(mc_data_hi_in));
        @(posedge aclk);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        forever #25 aclk = ~aclk;
    end

    initial begin
        #500000;
        num_errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(97061));
        foreach (codes[c]) begin
            cur = strap_map(codes[c]);
            aresetn <= 1'b0;
            strap <= codes[c];
            repeat (4) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (2) @(posedge aclk);
            rchk(OFS_MEM, {24'h0, cur}, RESP_OKAY);
            rchk(OFS_STAT, {4'h0, own_mask(cur), codes[c]},
                 RESP_OKAY);
            repeat (2) stir_and_check(cur);
        end
        for (int n = 0; n < 10; n++) begin
            // Full-rate flag kept at zero, so no soft reset is owed
            cur[4:0] = n < 2 ? 5'(n * 16) : 5'($urandom_range(16));
            cur[7:5] = {1'b0, 2'($urandom)};
            wr(OFS_MEM, {24'h0, cur}, 4'hF, r);
            chk("bresp", 32'(RESP_OKAY), 32'(r));
            stir_and_check(cur);
            rchk(OFS_STAT, {4'h0, own_mask(cur), 4'h5},
                 RESP_OKAY);
        end
        for (int a = 0; a < 5; a++) begin
            if (a == 2) continue;
            regs_m[a] = $urandom;
            wr(8'(a * 4), regs_m[a], 4'hF, r);
            v = $urandom;
            s = 4'($urandom);
            wr(8'(a * 4), v, s, r);
            for (int b = 0; b < 4; b++) begin
                if (s[b]) regs_m[a][8*b +: 8] = v[8*b +: 8];
            end
            rchk(8'(a * 4), regs_m[a], RESP_OKAY);
        end
        chk("vin", regs_m[0], video_in_mux);
        chk("vout", regs_m[1], video_out_mux);
        chk("gio", regs_m[3], gen_io_mux);
        chk("ser", regs_m[4], serial_card_mux);
        wr(8'h18, v, 4'hF, r);
        chk("bresp", 32'(RESP_SLVERR), 32'(r));
        wr(OFS_STAT, v, 4'hF, r);
        chk("bresp", 32'(RESP_OKAY), 32'(r));
        rchk(8'h18, 32'h0, RESP_SLVERR);
        rchk(OFS_STAT, {4'h0, own_mask(cur), 4'h5}, RESP_OKAY);
        wrap_up();
    end
endmodule // ext_mem_pin_partition_mux_test
`default_nettype wire
